// ==== rtl/rml_pkg.sv ====
// Purpose: Shared constants for the reset, mode and address latch control block.
// Assumes: One 20 MHz clock; registers are reached over Avalon-MM.
// Notes:   Byte address of a register is four times its index.
package rml_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned AV_ADDR_W      = 10;
  localparam logic [7:0]  IDX_AUX        = 8'h8e;
  localparam logic [7:0]  IDX_MODE       = 8'h90;
  localparam logic [7:0]  IDX_STATUS     = 8'h91;
  localparam logic [9:0]  OFS_AUX        = {IDX_AUX, 2'b00};
  localparam logic [9:0]  OFS_MODE       = {IDX_MODE, 2'b00};
  localparam logic [9:0]  OFS_STATUS     = {IDX_STATUS, 2'b00};

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned AUX_AO_BIT     = 0;
  localparam int unsigned AUX_EXPANDED_DATA_RAM_BIT   = 1;
  localparam logic [1:0]  AUX_RESET      = 2'h0;
  localparam int unsigned MODE_SIX_BIT   = 0;
  localparam logic        MODE_RESET     = 1'b0;
  localparam int unsigned STAT_RST_BIT   = 0;
  localparam int unsigned STAT_HOST_BIT  = 1;
  localparam int unsigned STAT_FEXT_BIT  = 2;

  // ---------------------------------------------------------------------------
  // Expanded data RAM window
  // ---------------------------------------------------------------------------
  localparam logic [15:0] EXPANDED_DATA_RAM_TOP       = 16'h0300;
  localparam int unsigned EXPANDED_DATA_RAM_DEPTH     = 768;

  // ---------------------------------------------------------------------------
  // Timing counts in clocks and machine cycles
  // ---------------------------------------------------------------------------
  localparam int unsigned MC_CLKS_STD    = 12;
  localparam int unsigned MC_CLKS_SIX    = 6;
  localparam int unsigned RESET_MCS      = 2;
  localparam logic [4:0]  RESET_CLKS_STD = 5'(RESET_MCS * MC_CLKS_STD);
  localparam logic [4:0]  RESET_CLKS_SIX = 5'(RESET_MCS * MC_CLKS_SIX);
  localparam logic [2:0]  ALE_DIV_STD    = 3'(MC_CLKS_STD / 2);
  localparam logic [2:0]  ALE_DIV_SIX    = 3'(MC_CLKS_SIX / 2);
  localparam logic [2:0]  ALE_HI_STD     = 3'h2;
  localparam logic [2:0]  ALE_HI_SIX     = 3'h1;

endpackage

// ==== rtl/rml_reset_ctl.sv ====
// Purpose: Reset pin qualifier, boot mode pick and fetch strap capture.
// Assumes: All pins are synchronous to mclk_in.
// Notes:   Mode and strap are caught on the cycle the device reset releases.
`timescale 1ns/1ps
`default_nettype none
module rml_reset_ctl (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Pins and mode
  input  wire logic reset_pin_in,
  input  wire logic program_store_strobe_pin_in,
  input  wire logic external_fetch_strap_in,
  input  wire logic six_clock_in,
  // State
  output logic      dev_reset_out,
  output logic      host_mode_out,
  output logic      fetch_external_out
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] limit;
  logic       program_store_strobe_pin_prev_q;
  logic       host_seen_q;
  logic       init_q;
  wire        program_store_strobe_pin_fall = program_store_strobe_pin_prev_q & ~program_store_strobe_pin_in;
  wire        release_now = (dev_reset_out & ~reset_pin_in) | init_q;

  assign limit = six_clock_in ? rml_pkg::RESET_CLKS_SIX : rml_pkg::RESET_CLKS_STD;
  assign cnt_d = !reset_pin_in ? 5'h00 : (cnt_q == limit) ? cnt_q : cnt_q + 5'h01;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt_q              <= 5'h00;
      dev_reset_out      <= 1'b0;
      program_store_strobe_pin_prev_q        <= 1'b1;
      host_seen_q        <= 1'b0;
      init_q             <= 1'b1;
      host_mode_out      <= 1'b0;
      fetch_external_out <= 1'b0;
    end else begin
      init_q        <= 1'b0;
      program_store_strobe_pin_prev_q   <= program_store_strobe_pin_in;
      cnt_q         <= cnt_d;
      dev_reset_out <= reset_pin_in & (cnt_d == limit); // [R1]
      if (!reset_pin_in) begin
        host_seen_q <= 1'b0;
      end else if (program_store_strobe_pin_fall) begin
        host_seen_q <= 1'b1; // [R2]
      end
      if (release_now) begin
        host_mode_out      <= host_seen_q & dev_reset_out; // [R2]
        fetch_external_out <= ~external_fetch_strap_in;    // [R3]
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rml_ale_gen.sv ====
// Purpose: Free running address latch strobe with skip and disable.
// Assumes: Six-clock mode halves the strobe period.
// Notes:   start_out is high in the clock before a pulse rises.
`timescale 1ns/1ps
`default_nettype none
module rml_ale_gen (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic six_clock_in,
  input  wire logic disable_in,
  input  wire logic force_in,
  input  wire logic skip_in,
  // Strobe
  output logic      ale_out,
  output logic      start_out
);

  logic [2:0] phase_q;
  logic [2:0] phase_d;
  logic       gate_q;
  logic       gate_d;
  logic       skip_q;
  logic       mode_q;
  logic [2:0] div;
  logic [2:0] hi;
  wire        wrap = (phase_q == div - 3'h1);

  // The mode is taken only at a period boundary, so a switch never cuts a pulse or a gap.
  assign div     = mode_q ? rml_pkg::ALE_DIV_SIX : rml_pkg::ALE_DIV_STD; // [R5] [R6]
  assign hi      = mode_q ? rml_pkg::ALE_HI_SIX : rml_pkg::ALE_HI_STD;
  assign phase_d = (phase_q >= div - 3'h1) ? 3'h0 : phase_q + 3'h1;
  // A pending skip eats exactly the next pulse; disable drops all but forced ones.
  assign gate_d    = wrap ? (~skip_q & (~disable_in | force_in)) : gate_q; // [R7] [R8]
  assign start_out = wrap & gate_d;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase_q <= 3'h0;
      gate_q  <= 1'b0;
      skip_q  <= 1'b0;
      mode_q  <= rml_pkg::MODE_RESET;
      ale_out <= 1'b0;
    end else begin
      phase_q <= phase_d;
      mode_q  <= wrap ? six_clock_in : mode_q; // [R6]
      gate_q  <= gate_d;
      skip_q  <= skip_in | (skip_q & ~wrap); // [R7]
      ale_out <= gate_d & (phase_d < hi);    // [R4]
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rml_top.sv ====
// Purpose: Reset and boot mode control, address latch strobe and data move routing.
// Assumes: Core side holds a data move request until it sees the one-cycle ack.
// Notes:   Expanded data RAM is flip-flops; external moves use the muxed port bus.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - A reset pin held high for two machine cycles resets the device.
// R2 - A falling program store strobe during reset selects host mode, otherwise normal mode.
// R3 - A low fetch strap selects external code fetch, a high one internal execution.
// R4 - The address latch strobe marks the low address byte of every external access.
// R5 - In the default mode the strobe pulses at one sixth of the clock rate.
// R6 - In six-clock mode the strobe pulses at one third of the clock rate.
// R7 - Each external data access drops exactly one strobe pulse.
// R8 - Setting the strobe disable bit stops the free running strobe pulses.
// R9 - Reserved register bits are written as zero and read with no promised value.
// R10 - Bits fixed at zero read zero and bits fixed at one read one.
// R11 - With internal RAM selected, moves below 0300h use on-chip RAM with no strobes.
// R12 - With external RAM selected, every data move uses the port bus and strobes.
// R13 - On-chip RAM accesses leave the port bus and strobe pins untouched.
// R14 - The auxiliary register resets with both of its control bits cleared.
module rml_top #(
  parameter int unsigned EXPANDED_DATA_RAM_DEPTH = rml_pkg::EXPANDED_DATA_RAM_DEPTH
) (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  // Avalon-MM slave
  input  wire logic [rml_pkg::AV_ADDR_W-1:0] avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [31:0]                   avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [31:0]                   avs_readdata_out,
  output logic                               avs_waitrequest_out,
  // Reset and strap pins
  input  wire logic                          reset_pin_in,
  input  wire logic                          program_store_strobe_pin_in,
  input  wire logic                          external_fetch_strap_in,
  output logic                               dev_reset_out,
  output logic                               host_mode_out,
  output logic                               fetch_external_out,
  // Address latch strobe pin
  output logic                               ale_out,
  output logic                               ale_oe_out,
  // Core data move request
  input  wire logic                          xreq_in,
  input  wire logic                          xwrite_in,
  input  wire logic                          xindirect_ri_in,
  input  wire logic [15:0]                   xaddr_in,
  input  wire logic [7:0]                    xwdata_in,
  output logic                               xack_out,
  output logic      [7:0]                    xrdata_out,
  // External muxed bus
  input  wire logic [7:0]                    port0_in,
  output logic      [7:0]                    port0_out,
  output logic                               port0_oe_out,
  output logic      [7:0]                    port2_out,
  output logic                               port2_oe_out,
  output logic                               rd_n_out,
  output logic                               wr_n_out
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LATCH, ST_DATA, ST_ACK} rml_state_e;

  // ---------------------------------------------------------------------------
  // Registers and helpers
  // ---------------------------------------------------------------------------
  rml_state_e state_q;
  rml_state_e state_d;
  logic [1:0] aux_q;
  logic       six_q;
  logic       wait_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] expanded_data_ram_q [EXPANDED_DATA_RAM_DEPTH];
  logic       dev_reset;
  logic       host_mode;
  logic       fetch_ext;
  logic       ale;
  logic       ale_start;
  logic [2:0] ale_div;
  logic [2:0] ale_hi;

  function automatic logic [31:0] bytew(input logic [7:0] b);
    bytew = {24'h000000, b};
  endfunction

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  wire        hit_aux    = (avs_address_in == rml_pkg::OFS_AUX);
  wire        hit_mode   = (avs_address_in == rml_pkg::OFS_MODE);
  wire        hit_stat   = (avs_address_in == rml_pkg::OFS_STATUS);
  wire        wr_commit  = avs_write_in & ~wait_q & avs_byteenable_in[0];
  // Reserved bits read zero and fixed bits return their constant.
  wire [7:0]  aux_rd     = {6'h00, aux_q};                                    // [R9] [R10]
  wire [7:0]  mode_rd    = {7'h00, six_q};                                    // [R10]
  wire [7:0]  stat_rd    = {5'h00, fetch_ext, host_mode, dev_reset};
  wire [31:0] rd_value   = hit_aux  ? bytew(aux_rd)  :
                           hit_mode ? bytew(mode_rd) :
                           hit_stat ? bytew(stat_rd) : 32'h00000000;

  // ---------------------------------------------------------------------------
  // Data move routing
  // ---------------------------------------------------------------------------
  wire        ext_ram    = aux_q[rml_pkg::AUX_EXPANDED_DATA_RAM_BIT];
  wire        ale_dis    = aux_q[rml_pkg::AUX_AO_BIT];
  // Indirect 8-bit moves reach only the low page of on-chip RAM.
  wire        go_int     = ~ext_ram & (xindirect_ri_in | (xaddr_in < rml_pkg::EXPANDED_DATA_RAM_TOP)); // [R11]
  wire        go_ext     = ~go_int;                                                      // [R12]
  wire [9:0]  ram_idx    = xindirect_ri_in ? {2'b00, xaddr_in[7:0]} : xaddr_in[9:0];
  wire        take       = (state_q == ST_IDLE) & xreq_in & ~dev_reset;
  wire        int_take   = take & go_int;
  wire        in_bus     = (state_d == ST_ADDR) | (state_d == ST_LATCH) | (state_d == ST_DATA);
  wire        in_data    = (state_d == ST_DATA);
  wire        skip_req   = (state_q == ST_LATCH) & (state_d == ST_DATA);
  wire        data_done  = (state_q == ST_DATA) & (cnt_q == 3'h1);

  assign avs_waitrequest_out = wait_q;
  assign ale_div = six_q ? rml_pkg::ALE_DIV_SIX : rml_pkg::ALE_DIV_STD;
  assign ale_hi  = six_q ? rml_pkg::ALE_HI_SIX : rml_pkg::ALE_HI_STD;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = go_int ? ST_ACK : ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (ale_start) begin
          state_d = ST_LATCH;
          // One extra clock holds the address on port 0 until the edge on which the pin strobe falls.
          cnt_d   = ale_hi + 3'h1; // [R4]
        end
      end
      ST_LATCH: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = ST_DATA;
          cnt_d   = ale_div;
        end
      end
      ST_DATA: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  rml_reset_ctl u_reset (
    .mclk_in                     (mclk_in),
    .rst_n_in                    (rst_n_in),
    .reset_pin_in                (reset_pin_in),
    .program_store_strobe_pin_in (program_store_strobe_pin_in),
    .external_fetch_strap_in     (external_fetch_strap_in),
    .six_clock_in                (six_q),
    .dev_reset_out               (dev_reset),
    .host_mode_out               (host_mode),
    .fetch_external_out          (fetch_ext)
  );

  rml_ale_gen u_ale (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .six_clock_in (six_q),
    .disable_in   (ale_dis),
    .force_in     (state_q == ST_ADDR),
    .skip_in      (skip_req),
    .ale_out      (ale),
    .start_out    (ale_start)
  );

  // ---------------------------------------------------------------------------
  // Bus slave and control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wait_q           <= 1'b1;
      avs_readdata_out <= 32'h00000000;
      aux_q            <= rml_pkg::AUX_RESET;
      six_q            <= rml_pkg::MODE_RESET;
    end else begin
      wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
      if ((avs_read_in | avs_write_in) & wait_q) begin
        avs_readdata_out <= rd_value;
      end
      if (dev_reset) begin
        aux_q <= rml_pkg::AUX_RESET; // [R14]
      end else if (wr_commit & hit_aux) begin
        aux_q <= avs_writedata_in[1:0]; // [R8] [R9]
      end
      if (wr_commit & hit_mode) begin
        six_q <= avs_writedata_in[rml_pkg::MODE_SIX_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Data move engine and pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (int_take & xwrite_in) begin
      expanded_data_ram_q[ram_idx] <= xwdata_in; // [R11]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || dev_reset) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 3'h0;
      xack_out     <= 1'b0;
      xrdata_out   <= 8'h00;
      port0_out    <= 8'h00;
      port0_oe_out <= 1'b0;
      port2_out    <= 8'h00;
      port2_oe_out <= 1'b0;
      rd_n_out     <= 1'b1;
      wr_n_out     <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      xack_out <= (state_d == ST_ACK);
      if (int_take & ~xwrite_in) begin
        xrdata_out <= expanded_data_ram_q[ram_idx]; // [R13]
      end else if (data_done & ~xwrite_in) begin
        xrdata_out <= port0_in;
      end
      if (take & go_ext) begin
        port0_out    <= xaddr_in[7:0];                // [R4] [R12]
        port2_out    <= xaddr_in[15:8];
        port2_oe_out <= ~xindirect_ri_in;
      end else if (skip_req & xwrite_in) begin
        port0_out <= xwdata_in;
      end
      if (!in_bus) begin
        port2_oe_out <= 1'b0;
      end
      port0_oe_out <= in_bus & (~in_data | xwrite_in); // [R12]
      rd_n_out     <= ~(in_data & ~xwrite_in);        // [R12]
      wr_n_out     <= ~(in_data & xwrite_in);
    end
  end

  // ---------------------------------------------------------------------------
  // Strobe pin and status outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ale_out            <= 1'b0;
      ale_oe_out         <= 1'b1;
      dev_reset_out      <= 1'b0;
      host_mode_out      <= 1'b0;
      fetch_external_out <= 1'b0;
    end else begin
      ale_out            <= ale;         // [R4] [R5] [R6]
      ale_oe_out         <= ~host_mode;  // [R2]
      dev_reset_out      <= dev_reset;   // [R1]
      host_mode_out      <= host_mode;
      fetch_external_out <= fetch_ext;   // [R3]
    end
  end

endmodule
`default_nettype wire

// ==== sim/rml_top_assertions.sv ====
// Purpose: Port level checks for the reset, mode and address latch control block.
// Assumes: One clock domain; rst_n_in is synchronous and active low.
// Notes:   Strobe figures hold in both the standard and the six-clock mode.
`timescale 1ns/1ps
`default_nettype none
module rml_top_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Observed ports
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic reset_pin_in,
  input wire logic dev_reset_out,
  input wire logic ale_out,
  input wire logic xack_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic port0_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Counts consecutive high samples of the reset pin.
  logic [4:0] pin_cnt_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !reset_pin_in) pin_cnt_q <= 5'h00;
    else if (pin_cnt_q != 5'h1f) pin_cnt_q <= pin_cnt_q + 5'h01;
  end
  chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest not low one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  chk_ale_width: assert property ($rose(ale_out) |-> ##2 !ale_out)
    else $error("strobe pulse too wide");
  chk_ale_gap: assert property ($fell(ale_out) |-> !ale_out[*2])
    else $error("strobe low phase too short");
  chk_dev_reset: assert property ($rose(dev_reset_out) |-> reset_pin_in && pin_cnt_q >= 5'h0c)
    else $error("device reset without a long enough pin pulse");
  chk_ack_pulse: assert property (xack_out |=> !xack_out)
    else $error("data move ack longer than one cycle");
  chk_rd_wr_excl: assert property (!(!rd_n_out && !wr_n_out))
    else $error("read and write strobes low together");
  chk_rd_hold: assert property ($fell(rd_n_out) |-> !rd_n_out[*3])
    else $error("read strobe too short");
  chk_rd_release: assert property (!rd_n_out |-> !port0_oe_out)
    else $error("port 0 driven while reading");
  chk_wr_drive: assert property (!wr_n_out |-> port0_oe_out)
    else $error("port 0 not driven while writing");
endmodule
bind rml_top rml_top_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .reset_pin_in(reset_pin_in),
  .dev_reset_out(dev_reset_out), .ale_out(ale_out), .xack_out(xack_out), .rd_n_out(rd_n_out),
  .wr_n_out(wr_n_out), .port0_oe_out(port0_oe_out));
`default_nettype wire

// ==== sim/rml_ext_mem.sv ====
// Purpose: External data memory on the muxed port bus.
// Assumes: Address is latched while the strobe is high and port 0 is driven.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module rml_ext_mem (
  // Clock
  input  wire logic        mclk_in,
  // Bus from the block
  input  wire logic        ale_in,
  input  wire logic [7:0]  p0_in,
  input  wire logic        p0_oe_in,
  input  wire logic [7:0]  p2_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  // Bus to the block and latched address
  output logic      [7:0]  data_out,
  output logic      [15:0] latched_out
);
  logic [7:0]  mem [0:255];
  logic [7:0]  last_q = 8'h00;
  logic [15:0] lat_q  = 16'h0000;
  always_ff @(posedge mclk_in) begin
    if (ale_in && p0_oe_in) lat_q <= {p2_in, p0_in};
    if (!wr_n_in) mem[lat_q[7:0]] <= p0_in;
    last_q <= data_out;
  end
  assign data_out    = !rd_n_in ? mem[lat_q[7:0]] : ~last_q;
  assign latched_out = lat_q;
endmodule
`default_nettype wire

// ==== sim/tb_rml_top.sv ====
// Purpose: Self-checking bench for the reset, mode and address latch control block.
// Assumes: Avalon master waits for waitrequest low; data moves wait for ack.
// Notes:   Strobe timing is measured at falling edges where outputs are settled.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_rml_top;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [9:0] avs_address_in = 10'h000;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic avs_waitrequest_out, reset_pin_in = 1'b0, program_store_strobe_pin = 1'b1, strap = 1'b1;
  logic dev_reset_out, host_mode_out, fetch_external_out, ale_out, ale_oe_out;
  logic xreq = 1'b0, xwrite = 1'b0, xri = 1'b0, xack_out, rd_n_out, wr_n_out;
  logic [15:0] xaddr = 16'h0, latched;
  logic [7:0] xwdata = 8'h0, xrdata_out, port0_in, port0_out, port2_out, q8;
  logic port0_oe_out, port2_oe_out, ale_p = 1'b0, bus_used;
  logic [31:0] q;
  int err_count = 0, checks = 0, since = 0, gap_max = 0, gap_min = 99, hi = 0, hi_last = 0, nrise = 0;
  rml_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .reset_pin_in(reset_pin_in), .program_store_strobe_pin_in(program_store_strobe_pin), .external_fetch_strap_in(strap),
    .dev_reset_out(dev_reset_out), .host_mode_out(host_mode_out), .fetch_external_out(fetch_external_out),
    .ale_out(ale_out), .ale_oe_out(ale_oe_out), .xreq_in(xreq), .xwrite_in(xwrite), .xindirect_ri_in(xri),
    .xaddr_in(xaddr), .xwdata_in(xwdata), .xack_out(xack_out), .xrdata_out(xrdata_out), .port0_in(port0_in),
    .port0_out(port0_out), .port0_oe_out(port0_oe_out), .port2_out(port2_out), .port2_oe_out(port2_oe_out),
    .rd_n_out(rd_n_out), .wr_n_out(wr_n_out));
  rml_ext_mem u_mem (.mclk_in(mclk_in), .ale_in(ale_out), .p0_in(port0_out), .p0_oe_in(port0_oe_out),
    .p2_in(port2_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .data_out(port0_in), .latched_out(latched));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  // Strobe period, high width and rise count, measured at falling edges.
  always @(negedge mclk_in) begin
    since++;
    if (ale_out) hi++;
    if (!ale_out && ale_p) hi_last = hi;
    if (!ale_out) hi = 0;
    if (ale_out && !ale_p) begin
      nrise++;
      if (since > gap_max) gap_max = since;
      if (since < gap_min) gap_min = since;
      since = 0;
    end
    ale_p = ale_out;
  end
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_read_in <= !wr;
    avs_write_in <= wr;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin err_count++; complete_run(); end
    r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic move(input logic wr, input logic ri, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk_in);
    xreq <= 1'b1;
    xwrite <= wr;
    xri <= ri;
    xaddr <= a;
    xwdata <= d;
    n = 0;
    bus_used = 1'b0;
    do begin
      @(posedge mclk_in);
      n++;
      if (rd_n_out !== 1'b1 || wr_n_out !== 1'b1 || port0_oe_out !== 1'b0 || port2_oe_out !== 1'b0) bus_used = 1'b1;
    end while (xack_out !== 1'b1 && n < 100);
    if (n >= 100) begin err_count++; complete_run(); end
    q8 = xrdata_out;
    xreq <= 1'b0;
  endtask
  task automatic t_regs();
    bus(1'b0, rml_pkg::OFS_AUX, 8'h00, q);
    `CHK(q, 32'h0)
    bus(1'b0, 10'h000, 8'h00, q);
    `CHK(q, 32'h0)
    bus(1'b1, rml_pkg::OFS_AUX, 8'h03, q);
    bus(1'b0, rml_pkg::OFS_AUX, 8'h00, q);
    `CHK(q[31:8], 24'h0)
    `CHK(q[1:0], 2'h3)
    bus(1'b1, rml_pkg::OFS_AUX, 8'h00, q);
    $display("test regs done");
  endtask
  task automatic t_rate(input logic six, input int per, input int wid);
    bus(1'b1, rml_pkg::OFS_MODE, {7'h0, six}, q);
    cyc(12);
    gap_max = 0;
    gap_min = 99;
    cyc(30);
    `CHK(gap_max, per)
    `CHK(gap_min, per)
    `CHK(hi_last, wid)
    bus(1'b1, rml_pkg::OFS_MODE, 8'h00, q);
    $display("test rate done");
  endtask
  task automatic t_off();
    int r;
    bus(1'b1, rml_pkg::OFS_AUX, 8'h01, q);
    cyc(4);
    r = nrise;
    cyc(30);
    `CHK(nrise, r)
    bus(1'b1, rml_pkg::OFS_AUX, 8'h00, q);
    $display("test disable done");
  endtask
  task automatic t_moves();
    move(1'b1, 1'b0, 16'h00a0, 8'hc3);
    `CHK(bus_used, 1'b0)
    move(1'b0, 1'b0, 16'h00a0, 8'h00);
    `CHK(q8, 8'hc3)
    `CHK(bus_used, 1'b0)
    move(1'b1, 1'b1, 16'h0500, 8'h11);
    `CHK(bus_used, 1'b0)
    move(1'b1, 1'b0, 16'h0400, 8'h33);
    `CHK(bus_used, 1'b1)
    bus(1'b1, rml_pkg::OFS_AUX, 8'h02, q);
    cyc(8);
    gap_max = 0;
    move(1'b1, 1'b0, 16'h1234, 8'h5a);
    `CHK(latched, 16'h1234)
    cyc(20);
    `CHK(gap_max, 12)
    move(1'b0, 1'b0, 16'h1234, 8'h00);
    `CHK(q8, 8'h5a)
    `CHK(bus_used, 1'b1)
    bus(1'b1, rml_pkg::OFS_AUX, 8'h00, q);
    $display("test moves done");
  endtask
  task automatic t_devrst();
    bus(1'b1, rml_pkg::OFS_AUX, 8'h01, q);
    strap <= 1'b0;
    reset_pin_in <= 1'b1;
    cyc(10);
    reset_pin_in <= 1'b0;
    cyc(3);
    `CHK(dev_reset_out, 1'b0)
    reset_pin_in <= 1'b1;
    cyc(10);
    program_store_strobe_pin <= 1'b0;
    cyc(20);
    `CHK(dev_reset_out, 1'b1)
    reset_pin_in <= 1'b0;
    program_store_strobe_pin <= 1'b1;
    cyc(3);
    `CHK(host_mode_out, 1'b1)
    `CHK(fetch_external_out, 1'b1)
    `CHK(ale_oe_out, 1'b0)
    bus(1'b0, rml_pkg::OFS_STATUS, 8'h00, q);
    `CHK(q[2:0], 3'h6)
    bus(1'b0, rml_pkg::OFS_AUX, 8'h00, q);
    `CHK(q[1:0], 2'h0)
    strap <= 1'b1;
    reset_pin_in <= 1'b1;
    cyc(30);
    reset_pin_in <= 1'b0;
    cyc(3);
    `CHK(host_mode_out, 1'b0)
    `CHK(fetch_external_out, 1'b0)
    `CHK(ale_oe_out, 1'b1)
    $display("test device reset done");
  endtask
  initial begin
    cyc(20);
    rst_n_in <= 1'b1;
    cyc(2);
    t_regs();
    t_rate(1'b0, 6, 2);
    t_rate(1'b1, 3, 1);
    t_off();
    t_moves();
    t_devrst();
    complete_run();
  end
endmodule
`default_nettype wire
